// ===== logic/event_ctrl_pkg.sv
`default_nettype none
package event_ctrl_pkg;

	// Register map.
	localparam logic [7:0] EVENT_CONTROL_ADDR = 8'h13;
	localparam logic [7:0] EVENT_CONTROL_RESET = 8'h00;
	localparam logic [7:0] EVENT_CONTROL_WMASK = 8'h77;
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

	// Field positions inside the event control register.
	localparam int LEVEL_SELECT_BIT = 6;
	localparam int FILTER_PERIOD_LSB = 4;
	localparam int STAMP_CLEAR_BIT = 2;
	localparam int STAMP_OVERWRITE_BIT = 1;
	localparam int STAMP_SOURCE_BIT = 0;

	// Filter sampling periods in clock cycles, one per nonzero field code.
	localparam int FILTER_CNT_W = 16;
	localparam logic [15:0] FILTER_PERIOD_1 = 16'h0008;
	localparam logic [15:0] FILTER_PERIOD_2 = 16'h0020;
	localparam logic [15:0] FILTER_PERIOD_3 = 16'h0080;

	// Synchroniser and edge-detector reset levels.
	localparam logic SYNC_RESET = 1'b0;
	localparam logic ACTIVE_PREV_RESET = 1'b1;

	typedef struct packed {
		logic level_select;
		logic [1:0] filter_period_select;
		logic stamp_clear;
		logic stamp_overwrite;
		logic stamp_source_select;
	} event_control_s;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_s;

endpackage
`default_nettype wire

// ===== logic/glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none
module glitch_filter #(
	parameter int CNT_W = event_ctrl_pkg::FILTER_CNT_W,
	parameter logic [15:0] PERIOD_1 = event_ctrl_pkg::FILTER_PERIOD_1,
	parameter logic [15:0] PERIOD_2 = event_ctrl_pkg::FILTER_PERIOD_2,
	parameter logic [15:0] PERIOD_3 = event_ctrl_pkg::FILTER_PERIOD_3
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Filter control and data.
	input wire logic [1:0] period_sel,
	input wire logic sample_in,
	output logic filtered
);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic prev_r;
	logic prev_nxt;
	logic filt_r;
	logic filt_nxt;

	function automatic logic [CNT_W-1:0] period_of(input logic [1:0] sel);
		case (sel)
			2'h1: period_of = CNT_W'(PERIOD_1 - 16'h0001);
			2'h2: period_of = CNT_W'(PERIOD_2 - 16'h0001);
			2'h3: period_of = CNT_W'(PERIOD_3 - 16'h0001);
			default: period_of = '0;
		endcase
	endfunction

	// Periodic sampling filter.
	// With a nonzero period code a new level is taken only when two successive samples agree, so a pulse
	// shorter than one sampling period never reaches the event logic; code 0 passes the input straight through.
	always_comb begin
		cnt_nxt = cnt_r;
		prev_nxt = prev_r;
		filt_nxt = filt_r;
		if (period_sel == 2'h0) begin
			cnt_nxt = '0;
			prev_nxt = sample_in;
			filt_nxt = sample_in;
		end else if (cnt_r == '0) begin
			cnt_nxt = period_of(period_sel);
			prev_nxt = sample_in;
			if (sample_in == prev_r) begin
				filt_nxt = sample_in;
			end
		end else begin
			cnt_nxt = cnt_r - CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			prev_r <= 1'b0;
			filt_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			prev_r <= prev_nxt;
			filt_r <= filt_nxt;
		end
	end

	assign filtered = filt_r;

endmodule
`default_nettype wire

// ===== logic/event_control.sv
// Function
// - Level select bit chooses high or low input level as the event.
// - Input is glitch filtered by sampling at the period the filter field selects.
// - Switchover into backup supply can be chosen as an event source.
// - Register at 13h always readable; writes blocked while password protection active.
// - Bits 2..0 hold stamp clear, stamp overwrite and stamp source select.
// - Event source is filtered pin event or automatic backup switchover.
`timescale 1ns/1ps
`default_nettype none
module event_control #(
	parameter int CNT_W = event_ctrl_pkg::FILTER_CNT_W,
	parameter logic [15:0] PERIOD_1 = event_ctrl_pkg::FILTER_PERIOD_1,
	parameter logic [15:0] PERIOD_2 = event_ctrl_pkg::FILTER_PERIOD_2,
	parameter logic [15:0] PERIOD_3 = event_ctrl_pkg::FILTER_PERIOD_3
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Register access from the serial interface.
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic REG_RVALID,
	output logic REG_WR_REFUSED,
	// Password protection state.
	input wire logic WRITE_LOCK,
	// Event sources.
	input wire logic EVENT_INPUT_PIN,
	input wire logic BACKUP_SUPPLY,
	// Event and time stamp control towards the stamp logic.
	output logic EVENT_PULSE,
	output logic EVENT_LEVEL,
	output logic STAMP_CLEAR,
	output logic STAMP_CLEAR_PULSE,
	output logic STAMP_OVERWRITE,
	output logic STAMP_SOURCE_SELECT
);

	event_ctrl_pkg::reg_req_s req;
	event_ctrl_pkg::event_control_s ctrl_r;
	event_ctrl_pkg::event_control_s ctrl_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic refused_r;
	logic refused_nxt;
	logic clr_pulse_r;
	logic clr_pulse_nxt;
	logic hit;

	logic pin_meta_r;
	logic pin_sync_r;
	logic bk_meta_r;
	logic bk_sync_r;
	logic bk_prev_r;
	logic bk_prev_nxt;
	logic active_prev_r;
	logic active_prev_nxt;
	logic event_r;
	logic event_nxt;
	logic level_r;
	logic level_nxt;
	logic filtered;
	logic active;

	function automatic logic [7:0] pack_ctrl(input event_ctrl_pkg::event_control_s c);
		logic [7:0] v;
		v = 8'h00;
		v[event_ctrl_pkg::LEVEL_SELECT_BIT] = c.level_select;
		v[event_ctrl_pkg::FILTER_PERIOD_LSB +: 2] = c.filter_period_select;
		v[event_ctrl_pkg::STAMP_CLEAR_BIT] = c.stamp_clear;
		v[event_ctrl_pkg::STAMP_OVERWRITE_BIT] = c.stamp_overwrite;
		v[event_ctrl_pkg::STAMP_SOURCE_BIT] = c.stamp_source_select;
		pack_ctrl = v;
	endfunction

	function automatic event_ctrl_pkg::event_control_s unpack_ctrl(input logic [7:0] v);
		event_ctrl_pkg::event_control_s c;
		c.level_select = v[event_ctrl_pkg::LEVEL_SELECT_BIT];
		c.filter_period_select = v[event_ctrl_pkg::FILTER_PERIOD_LSB +: 2];
		c.stamp_clear = v[event_ctrl_pkg::STAMP_CLEAR_BIT];
		c.stamp_overwrite = v[event_ctrl_pkg::STAMP_OVERWRITE_BIT];
		c.stamp_source_select = v[event_ctrl_pkg::STAMP_SOURCE_BIT];
		unpack_ctrl = c;
	endfunction

	assign req.addr = REG_ADDR;
	assign req.wr = REG_WR;
	assign req.rd = REG_RD;
	assign req.wdata = REG_WDATA;
	assign hit = (req.addr == event_ctrl_pkg::EVENT_CONTROL_ADDR);

	// A read in the same cycle as a write returns the old contents, because the
	// read path looks at the register before the write lands.
	// Register file: write, read and refusal of locked writes.
	always_comb begin
		ctrl_nxt = ctrl_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		refused_nxt = 1'b0;
		clr_pulse_nxt = 1'b0;
		if (req.wr && hit) begin
			if (WRITE_LOCK) begin
				refused_nxt = 1'b1;
			end else begin
				ctrl_nxt = unpack_ctrl(req.wdata & event_ctrl_pkg::EVENT_CONTROL_WMASK);
				clr_pulse_nxt = req.wdata[event_ctrl_pkg::STAMP_CLEAR_BIT];
			end
		end
		if (req.rd) begin
			rvalid_nxt = 1'b1;
			if (hit) begin
				rdata_nxt = pack_ctrl(ctrl_r);
			end else begin
				rdata_nxt = event_ctrl_pkg::UNMAPPED_RDATA;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_r <= unpack_ctrl(event_ctrl_pkg::EVENT_CONTROL_RESET);
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
			refused_r <= 1'b0;
			clr_pulse_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			refused_r <= refused_nxt;
			clr_pulse_r <= clr_pulse_nxt;
		end
	end

	// Both pins are asynchronous to CLK and pass two flip-flops first.
	always_ff @(posedge CLK) begin
		if (RST) begin
			pin_meta_r <= event_ctrl_pkg::SYNC_RESET;
			pin_sync_r <= event_ctrl_pkg::SYNC_RESET;
			bk_meta_r <= event_ctrl_pkg::SYNC_RESET;
			bk_sync_r <= event_ctrl_pkg::SYNC_RESET;
		end else begin
			pin_meta_r <= EVENT_INPUT_PIN;
			pin_sync_r <= pin_meta_r;
			bk_meta_r <= BACKUP_SUPPLY;
			bk_sync_r <= bk_meta_r;
		end
	end

	glitch_filter #(
		.CNT_W(CNT_W),
		.PERIOD_1(PERIOD_1),
		.PERIOD_2(PERIOD_2),
		.PERIOD_3(PERIOD_3)
	) u_filter (
		.clk(CLK),
		.rst(RST),
		.period_sel(ctrl_r.filter_period_select),
		.sample_in(pin_sync_r),
		.filtered(filtered)
	);

	assign active = ctrl_r.level_select ? filtered : ~filtered;

	// Event detection. The previous active level resets high so that an idle
	// low pin right after reset is not taken as an event.
	always_comb begin
		active_prev_nxt = active;
		bk_prev_nxt = bk_sync_r;
		level_nxt = active;
		event_nxt = 1'b0;
		// Only the entry into backup supply is an event; the return to main
		// supply is not.
		// Event source choice.
		if (ctrl_r.stamp_source_select) begin
			event_nxt = bk_sync_r && !bk_prev_r;
		end else begin
			event_nxt = active && !active_prev_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			active_prev_r <= event_ctrl_pkg::ACTIVE_PREV_RESET;
			bk_prev_r <= 1'b0;
			level_r <= 1'b0;
			event_r <= 1'b0;
		end else begin
			active_prev_r <= active_prev_nxt;
			bk_prev_r <= bk_prev_nxt;
			level_r <= level_nxt;
			event_r <= event_nxt;
		end
	end

	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign REG_WR_REFUSED = refused_r;
	assign EVENT_PULSE = event_r;
	assign EVENT_LEVEL = level_r;
	// The clear bit is kept as written and is not self-clearing.
	// The pulse marks every accepted write that sets it, so the stamp logic
	// need not watch the bus itself.
	// Stamp control outputs.
	assign STAMP_CLEAR = ctrl_r.stamp_clear;
	assign STAMP_CLEAR_PULSE = clr_pulse_r;
	assign STAMP_OVERWRITE = ctrl_r.stamp_overwrite;
	assign STAMP_SOURCE_SELECT = ctrl_r.stamp_source_select;

endmodule
`default_nettype wire

// ===== tb/event_control_checker.sv
`timescale 1ns/1ps
`default_nettype none
module event_control_checker (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Register access.
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic REG_WR_REFUSED,
	input wire logic WRITE_LOCK,
	// Event and stamp outputs.
	input wire logic EVENT_PULSE,
	input wire logic STAMP_CLEAR_PULSE,
	input wire logic STAMP_OVERWRITE,
	input wire logic STAMP_SOURCE_SELECT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic hit;
	assign hit = REG_WR && REG_ADDR == 8'h13;
	a_read_answered: assert property (REG_RD |=> REG_RVALID)
		else $error("read not answered");
	a_rvalid_cause: assert property (REG_RVALID |-> $past(REG_RD))
		else $error("stray read valid");
	a_lock_refuses: assert property (hit && WRITE_LOCK |=> REG_WR_REFUSED)
		else $error("locked write not refused");
	a_refuse_cause: assert property (REG_WR_REFUSED |-> $past(hit && WRITE_LOCK))
		else $error("stray refusal");
	a_write_lands: assert property (hit && !WRITE_LOCK |=>
		{STAMP_OVERWRITE, STAMP_SOURCE_SELECT} == $past(REG_WDATA[1:0]))
		else $error("write not stored");
	a_clear_pulse: assert property (hit && !WRITE_LOCK && REG_WDATA[2] |=> STAMP_CLEAR_PULSE)
		else $error("no clear pulse");
	a_unmapped_zero: assert property (REG_RD && REG_ADDR != 8'h13 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (REG_RVALID |-> !REG_RDATA[7] && !REG_RDATA[3])
		else $error("reserved bit set");
	a_pulse_single: assert property (EVENT_PULSE |=> !EVENT_PULSE)
		else $error("event pulse too long");
	c_locked: cover property (hit && WRITE_LOCK);
	c_event: cover property (EVENT_PULSE);
	c_clear: cover property (STAMP_CLEAR_PULSE);
	c_backup: cover property (EVENT_PULSE && STAMP_SOURCE_SELECT);
endmodule
bind event_control event_control_checker chk_i (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD,
	.REG_WDATA, .REG_RDATA, .REG_RVALID, .REG_WR_REFUSED, .WRITE_LOCK, .EVENT_PULSE,
	.STAMP_CLEAR_PULSE, .STAMP_OVERWRITE, .STAMP_SOURCE_SELECT);
`default_nettype wire

// ===== tb/event_source.sv
`timescale 1ns/1ps
`default_nettype none
module event_source (
	// Clock.
	input wire logic clk,
	// Requested levels.
	input wire logic pin_req,
	input wire logic backup_req,
	// Lines into the device.
	output logic pin,
	output logic backup
);
	// Late changes keep the lines unrelated to the sampling edge.
	initial begin
		pin = 1'b0;
		backup = 1'b0;
		forever begin
			@(posedge clk);
			pin <= #7 pin_req;
			backup <= #7 backup_req;
		end
	end
endmodule
`default_nettype wire

// ===== tb/event_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_control_tb;
	logic CLK, RST, REG_WR, REG_RD, WRITE_LOCK, pin_req, bkp_req, EVENT_INPUT_PIN, BACKUP_SUPPLY;
	logic REG_RVALID, REG_WR_REFUSED, EVENT_PULSE, EVENT_LEVEL, STAMP_CLEAR, STAMP_CLEAR_PULSE;
	logic STAMP_OVERWRITE, STAMP_SOURCE_SELECT;
	logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, exp_reg, d;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	int w;
	event_control dut (.CLK, .RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA,
		.REG_RVALID, .REG_WR_REFUSED, .WRITE_LOCK, .EVENT_INPUT_PIN, .BACKUP_SUPPLY,
		.EVENT_PULSE, .EVENT_LEVEL, .STAMP_CLEAR, .STAMP_CLEAR_PULSE, .STAMP_OVERWRITE,
		.STAMP_SOURCE_SELECT);
	event_source src (.clk(CLK), .pin_req, .backup_req(bkp_req), .pin(EVENT_INPUT_PIN),
		.backup(BACKUP_SUPPLY));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic lk);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_WDATA <= v;
		WRITE_LOCK <= lk;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
		@(negedge CLK);
		chk(REG_WR_REFUSED, a == 8'h13 && lk);
		chk(STAMP_CLEAR_PULSE, a == 8'h13 && !lk && v[2]);
		if (a == 8'h13 && !lk) exp_reg = v & 8'h77;
		chk({STAMP_CLEAR, STAMP_OVERWRITE, STAMP_SOURCE_SELECT}, exp_reg[2:0]);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		@(negedge CLK);
		chk(REG_RVALID, 8'h01);
		chk(REG_RDATA, e);
	endtask
	task automatic events(input int cycles);
		n = 0;
		repeat (cycles) begin
			@(negedge CLK);
			if (EVENT_PULSE === 1'b1) n++;
		end
	endtask
	// Settling window for a filter code: three sample periods plus synchroniser slack.
	function automatic int filter_window(input logic [1:0] code);
		case (code)
			2'h1: filter_window = 3 * int'(event_ctrl_pkg::FILTER_PERIOD_1) + 8;
			2'h2: filter_window = 3 * int'(event_ctrl_pkg::FILTER_PERIOD_2) + 8;
			2'h3: filter_window = 3 * int'(event_ctrl_pkg::FILTER_PERIOD_3) + 8;
			default: filter_window = 8;
		endcase
	endfunction
	task automatic drive_pin(input logic v);
		@(posedge CLK);
		pin_req <= v;
	endtask
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		{RST, REG_WR, REG_RD, WRITE_LOCK, pin_req, bkp_req} = 6'h20;
		{REG_ADDR, REG_WDATA, exp_reg} = 24'h000000;
		void'($urandom(32'hff1d6bcb));
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		rdc(8'h13, 8'h00);
		for (int i = 0; i < 12; i++) begin
			d = 8'($urandom);
			wr((i == 5) ? 8'h14 : 8'h13, d, $urandom % 3 == 0);
			rdc(8'h13, exp_reg);
		end
		rdc(8'h14, 8'h00);
		wr(8'h13, 8'hff, 1'b0);
		rdc(8'h13, 8'h77);
		for (int p = 0; p < 2; p++) begin
			drive_pin(!p[0]);
			wr(8'h13, {1'b0, p[0], 6'h00}, 1'b0);
			events(12);
			drive_pin(p[0]);
			events(12);
			chk(8'(n), 8'h01);
			chk(EVENT_LEVEL, 8'h01);
		end
		wr(8'h13, 8'h01, 1'b0);
		events(12);
		@(posedge CLK);
		bkp_req <= 1'b1;
		events(12);
		chk(8'(n), 8'h01);
		for (int c = 1; c < 4; c++) begin
			w = filter_window(2'(c));
			drive_pin(1'b0);
			wr(8'h13, {2'b01, 2'(c), 4'h0}, 1'b0);
			events(w);
			drive_pin(1'b1);
			drive_pin(1'b1);
			drive_pin(1'b0);
			events(w);
			chk(8'(n), 8'h00);
			drive_pin(1'b1);
			events(w);
			chk(8'(n), 8'h01);
		end
		@(posedge CLK);
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		rdc(8'h13, 8'h00);
		chk({STAMP_CLEAR, STAMP_OVERWRITE, STAMP_SOURCE_SELECT}, 8'h00);
		tally_and_finish();
	end
endmodule
`default_nettype wire
